//--- rtl/rtca_pkg.sv
/*
  rtca_pkg: shared constants and types of the alarm and trim block.
  Assumes byte-wide registers on a five-bit address space behind SPI.
*/
package rtca_pkg;

  // register width and address space
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 5;
  localparam int          REG_DEPTH   = 32;

  // register addresses
  localparam logic [4:0]  ADDR_SECONDS  = 5'h01;
  localparam logic [4:0]  ADDR_DIG_CAL  = 5'h08;
  localparam logic [4:0]  ADDR_AL1_BASE = 5'h0A;
  localparam logic [4:0]  ADDR_AL1_LAST = 5'h0E;
  localparam logic [4:0]  ADDR_FLAGS    = 5'h0F;
  localparam logic [4:0]  ADDR_TRIM     = 5'h12;
  localparam logic [4:0]  ADDR_AL2_CTL  = 5'h13;
  localparam logic [4:0]  ADDR_AL2_BASE = 5'h14;
  localparam logic [4:0]  ADDR_AL2_LAST = 5'h18;

  // alarm bank byte index, offset from the bank base
  localparam int          AL_MONTH = 0;
  localparam int          AL_DATE  = 1;
  localparam int          AL_HOUR  = 2;
  localparam int          AL_MIN   = 3;
  localparam int          AL_SEC   = 4;
  localparam int          AL_BYTES = 5;

  // bit positions of control fields
  localparam int          BIT_OSC_STOP    = 7;  // seconds register
  localparam int          BIT_OUT_LEVEL   = 7;  // digital cal register
  localparam int          BIT_FREQ_TEST   = 6;  // digital cal register
  localparam int          BIT_A1_IRQ_EN   = 7;  // alarm month register
  localparam int          BIT_AL2_ENABLE  = 1;  // alarm 2 control register
  localparam int          BIT_RPT_HI      = 7;  // repeat bit in date, hour, minute and second bytes
  localparam int          BIT_RPT5        = 6;  // second repeat bit, date
  localparam int          BIT_TRIM_SIGN   = 7;

  // flags register layout
  localparam int          FLG_WATCHDOG = 7;
  localparam int          FLG_AF1      = 6;
  localparam int          FLG_AF2      = 5;
  localparam int          FLG_BATT_LOW = 4;
  localparam int          FLG_TIMER    = 3;
  localparam int          FLG_OSC_FAIL = 2;

  // reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic        RST_FLAG     = 1'b0;

  // trim, in quarter-picofarad units per crystal side
  localparam logic [7:0]  TRIM_SIDE_NOMINAL_QPF = 8'h64;  // 25 pF
  localparam logic [6:0]  TRIM_MAX_ADD_MAG      = 7'h27;  // code 00100111
  localparam logic [6:0]  TRIM_MAX_REMOVE_MAG   = 7'h48;  // code 11001000

  // spi command byte: top bit marks a write
  localparam int          SPI_WRITE_BIT = 7;
  localparam logic [2:0]  SPI_LAST_BIT  = 3'h7;

  // repeat modes of an alarm
  typedef enum logic [2:0] {
    RPT_SECOND,
    RPT_MINUTE,
    RPT_HOUR,
    RPT_DAY,
    RPT_MONTH,
    RPT_YEAR
  } rtca_rpt_mode_t;

endpackage : rtca_pkg

//--- rtl/rtca_mem_if.sv
/*
  rtca_mem_if: port of the register byte store.
  Assumes a single writer and a registered read of one address.
*/
`timescale 1ns/100ps
interface rtca_mem_if #(
  parameter int AW = 5,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          we;
  logic [DW-1:0] rdata;

  modport ctrl  (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface : rtca_mem_if

//--- rtl/rtca_regmem.sv
/*
  rtca_regmem: byte store behind the serial port, user storage included.
  Assumes the same clock and synchronous reset as its controller.
*/
`timescale 1ns/100ps
module rtca_regmem #(
  parameter int DEPTH = 32
) (
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  rtca_mem_if.store  mem
);
  logic [7:0] store_r [DEPTH];

  // write port, cleared at reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        store_r[i] <= rtca_pkg::RST_BYTE;
    end
    else if (mem.we)
      store_r[mem.addr] <= mem.wdata;
  end

  // registered read
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mem.rdata <= rtca_pkg::RST_BYTE;
    else
      mem.rdata <= store_r[mem.addr];
  end
endmodule : rtca_regmem

//--- rtl/rtca_trim_dec.sv
/*
  rtca_trim_dec: turns the load trim byte into a per-side capacitance code.
  Assumes the analog array accepts quarter-picofarad steps per side.
*/
`timescale 1ns/100ps
module rtca_trim_dec (
  input  wire logic [7:0] trim_code,
  output logic      [7:0] side_cap_qpf,
  output logic            trim_valid
);
  logic       trim_sign;
  logic [6:0] trim_magnitude;

  assign trim_sign      = trim_code[rtca_pkg::BIT_TRIM_SIGN];
  assign trim_magnitude = trim_code[6:0];  // weights 0.25pF .. 16pF

  // sign picks add or remove, out-of-range codes fall back to nominal
  always_comb
  begin
    trim_valid   = 1'b1;
    side_cap_qpf = rtca_pkg::TRIM_SIDE_NOMINAL_QPF;
    if (trim_magnitude == 7'h00)
      side_cap_qpf = rtca_pkg::TRIM_SIDE_NOMINAL_QPF;
    else if (!trim_sign)
    begin
      if (trim_magnitude <= rtca_pkg::TRIM_MAX_ADD_MAG)
        side_cap_qpf = rtca_pkg::TRIM_SIDE_NOMINAL_QPF
                       + {1'b0, trim_magnitude};  // adds load
      else
        trim_valid = 1'b0;
    end
    else
    begin
      if (trim_magnitude <= rtca_pkg::TRIM_MAX_REMOVE_MAG)
        side_cap_qpf = rtca_pkg::TRIM_SIDE_NOMINAL_QPF
                       - {1'b0, trim_magnitude};  // removes load
      else
        trim_valid = 1'b0;
    end
  end
endmodule : rtca_trim_dec

//--- rtl/rtca_top.sv
/*
  rtca_top: alarm matching, alarm flags, test output and load trim of a
  serial real-time clock, with the positive-clock SPI register port.
  Assumes the timekeeping counters and the oscillator divider chain sit
  outside on clk_sys; the SPI pins arrive asynchronous to clk_sys.
*/
// Contract
// - seven-bit trim magnitude, 0.25pF to 16pF
// - trim sign zero adds, one removes capacitance
// - zero magnitude gives nominal load
// - largest valid add and remove codes
// - invalid trim code falls back to 25pF
// - test and level bits, running oscillator: 512Hz
// - test output uses uncorrected divider timebase
// - alarm banks at 0Ah-0Eh and 14h-18h
// - each alarm has own match and repeat
// - repeat codes select second through year
// - undefined repeat codes act per second
// - match sets that alarm's flag
// - first alarm enable drives low output
// - pointer on flags address blocks alarms
// - reading flags clears flag and interrupt
// - clearing read still returns the set flag
// - matching keeps working on backup supply
// - second alarm only when enable bit set
// - flags register bit layout
`timescale 1ns/100ps
module rtca_top #(
  parameter int REG_DEPTH = 32
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       spi_scl,
  input  wire logic       spi_sdi,
  input  wire logic       spi_ce_n,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  input  wire logic       sec_tick,
  input  wire logic [6:0] cur_second,
  input  wire logic [6:0] cur_minute,
  input  wire logic [5:0] cur_hour,
  input  wire logic [5:0] cur_date,
  input  wire logic [4:0] cur_month,
  input  wire logic       tick_1024hz,
  input  wire logic       battery_low_flag,
  input  wire logic       oscillator_fail_flag,
  output logic            interrupt_test_output_n,
  output logic      [7:0] osc_side_cap_qpf,
  output logic            trim_code_valid
);

  // repeat bits of a bank, ordered fifth down to first
  function automatic logic [4:0] rtca_rpt_bits(
    input logic [4:0][7:0] bank
  );
    rtca_rpt_bits = {bank[rtca_pkg::AL_DATE][rtca_pkg::BIT_RPT5],
                     bank[rtca_pkg::AL_DATE][rtca_pkg::BIT_RPT_HI],
                     bank[rtca_pkg::AL_HOUR][rtca_pkg::BIT_RPT_HI],
                     bank[rtca_pkg::AL_MIN][rtca_pkg::BIT_RPT_HI],
                     bank[rtca_pkg::AL_SEC][rtca_pkg::BIT_RPT_HI]};
  endfunction : rtca_rpt_bits

  // repeat code to mode
  function automatic rtca_pkg::rtca_rpt_mode_t rtca_rpt_decode(
    input logic [4:0] rpt
  );
    case (rpt)
      5'h1F:   rtca_rpt_decode = rtca_pkg::RPT_SECOND;
      5'h1E:   rtca_rpt_decode = rtca_pkg::RPT_MINUTE;
      5'h1C:   rtca_rpt_decode = rtca_pkg::RPT_HOUR;
      5'h18:   rtca_rpt_decode = rtca_pkg::RPT_DAY;
      5'h10:   rtca_rpt_decode = rtca_pkg::RPT_MONTH;
      5'h00:   rtca_rpt_decode = rtca_pkg::RPT_YEAR;
      default: rtca_rpt_decode = rtca_pkg::RPT_SECOND;
    endcase
  endfunction : rtca_rpt_decode

  // compares one alarm bank against the current time under its mode
  function automatic logic rtca_alarm_match(
    input logic [4:0][7:0] bank,
    input logic      [6:0] sec,
    input logic      [6:0] min,
    input logic      [5:0] hour,
    input logic      [5:0] date,
    input logic      [4:0] month
  );
    logic eq_s;
    logic eq_m;
    logic eq_h;
    logic eq_d;
    logic eq_mo;
    eq_s  = bank[rtca_pkg::AL_SEC][6:0]   == sec;
    eq_m  = bank[rtca_pkg::AL_MIN][6:0]   == min;
    eq_h  = bank[rtca_pkg::AL_HOUR][5:0]  == hour;
    eq_d  = bank[rtca_pkg::AL_DATE][5:0]  == date;  // zero never hits
    eq_mo = bank[rtca_pkg::AL_MONTH][4:0] == month;
    unique case (rtca_rpt_decode(rtca_rpt_bits(bank)))
      rtca_pkg::RPT_SECOND: rtca_alarm_match = 1'b1;
      rtca_pkg::RPT_MINUTE: rtca_alarm_match = eq_s;
      rtca_pkg::RPT_HOUR:   rtca_alarm_match = eq_s & eq_m;
      rtca_pkg::RPT_DAY:    rtca_alarm_match = eq_s & eq_m & eq_h;
      rtca_pkg::RPT_MONTH:  rtca_alarm_match = eq_s & eq_m & eq_h & eq_d;
      rtca_pkg::RPT_YEAR:
        rtca_alarm_match = eq_s & eq_m & eq_h & eq_d & eq_mo;
    endcase
  endfunction : rtca_alarm_match

  // pin synchronisers and edge history
  logic [2:0] scl_sync_r;
  logic [1:0] sdi_sync_r;
  logic [2:0] ce_sync_r;
  logic [1:0] bl_sync_r;
  logic [1:0] of_sync_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       ce_active;
  logic       ce_start;

  // serial engine state
  logic [7:0] rx_r;
  logic [2:0] bit_cnt_r;
  logic       cmd_phase_r;
  logic       is_write_r;
  logic [4:0] ptr_r;
  logic [7:0] tx_r;
  logic       load_pend_r;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       tx_load;

  // registers snooped from writes
  logic [4:0][7:0] al1_r;
  logic [4:0][7:0] al2_r;
  logic [7:0]      trim_r;
  logic            al2_en_r;
  logic            osc_stop_r;
  logic            out_level_r;
  logic            freq_test_r;

  // alarm state
  logic            af1_r;
  logic            af2_r;
  logic            af1_nxt;
  logic            af2_nxt;
  logic            hit1;
  logic            hit2;
  logic            flags_clear;
  logic            ft_sq_r;
  logic            int_out_r;
  logic            int_out_nxt;
  logic            alarm_irq;
  logic [7:0]      flags_val;
  logic            wr_strobe;

  rtca_mem_if #(.AW(rtca_pkg::ADDR_W), .DW(rtca_pkg::DATA_W)) mem_bus ();

  // byte store for every register except flags, user bytes included
  rtca_regmem #(
    .DEPTH   (REG_DEPTH)
  ) u_regmem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .mem     (mem_bus.store)
  );

  // capacitance code for the oscillator load array
  rtca_trim_dec u_trim_dec (
    .trim_code    (trim_r),
    .side_cap_qpf (osc_side_cap_qpf),
    .trim_valid   (trim_code_valid)
  );

  // two-stage synchronisers, third stage only for edge history
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_sync_r <= 3'h0;
      sdi_sync_r <= 2'h0;
      ce_sync_r  <= 3'h7;
      bl_sync_r  <= 2'h0;
      of_sync_r  <= 2'h0;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[1:0], spi_scl};
      sdi_sync_r <= {sdi_sync_r[0], spi_sdi};
      ce_sync_r  <= {ce_sync_r[1:0], spi_ce_n};
      bl_sync_r  <= {bl_sync_r[0], battery_low_flag};
      of_sync_r  <= {of_sync_r[0], oscillator_fail_flag};
    end
  end

  // edges seen on the synchronised pins
  assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
  assign ce_active = ~ce_sync_r[1];
  assign ce_start  = ~ce_sync_r[1] & ce_sync_r[2];
  assign rx_byte   = {rx_r[6:0], sdi_sync_r[1]};
  assign byte_done = ce_active & scl_rise & (bit_cnt_r == rtca_pkg::SPI_LAST_BIT);

  // shift in on rising clock, count bits of the current byte
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_r      <= rtca_pkg::RST_BYTE;
      bit_cnt_r <= 3'h0;
    end
    else if (ce_start || !ce_active)
      bit_cnt_r <= 3'h0;
    else if (scl_rise)
    begin
      rx_r      <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // command byte sets direction and pointer; data bytes advance it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmd_phase_r <= 1'b1;
      is_write_r  <= 1'b0;
      ptr_r       <= 5'h00;
    end
    else if (ce_start)
      cmd_phase_r <= 1'b1;
    else if (byte_done && cmd_phase_r)
    begin
      cmd_phase_r <= 1'b0;
      is_write_r  <= rx_byte[rtca_pkg::SPI_WRITE_BIT];
      ptr_r       <= rx_byte[4:0];
    end
    else if ((byte_done && is_write_r) || tx_load)
      ptr_r <= ptr_r + 5'h01;  // pointer rests past last byte
  end

  // read data are loaded on the falling edge after a byte boundary
  assign tx_load = ce_active & scl_fall & load_pend_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      load_pend_r <= 1'b0;
    else if (!ce_active)
      load_pend_r <= 1'b0;
    else if (byte_done)
      load_pend_r <= cmd_phase_r ? ~rx_byte[rtca_pkg::SPI_WRITE_BIT]
                                 : ~is_write_r;
    else if (tx_load)
      load_pend_r <= 1'b0;
  end

  // flags as read; alarm flags shown before the read clears them
  always_comb
  begin
    flags_val                          = 8'h00;  // low bits zero
    flags_val[rtca_pkg::FLG_WATCHDOG]  = 1'b0;
    flags_val[rtca_pkg::FLG_AF1]       = af1_r;
    flags_val[rtca_pkg::FLG_AF2]       = af2_r;
    flags_val[rtca_pkg::FLG_BATT_LOW]  = bl_sync_r[1];
    flags_val[rtca_pkg::FLG_TIMER]     = 1'b0;
    flags_val[rtca_pkg::FLG_OSC_FAIL]  = of_sync_r[1];
  end

  // transmit shifter, msb first, shifted on falling clock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      tx_r <= rtca_pkg::RST_BYTE;
    else if (tx_load)
      tx_r <= (ptr_r == rtca_pkg::ADDR_FLAGS) ? flags_val
                                              : mem_bus.rdata;
    else if (ce_active && scl_fall)
      tx_r <= {tx_r[6:0], 1'b0};
  end

  // data out driven only while a read is selected
  assign spi_sdo    = tx_r[7];
  assign spi_sdo_oe = ce_active & ~is_write_r & ~cmd_phase_r & ~ce_start;

  // byte store port: reads follow the pointer, writes land on it
  assign wr_strobe     = byte_done & ~cmd_phase_r & is_write_r;
  assign mem_bus.addr  = ptr_r;
  assign mem_bus.wdata = rx_byte;
  assign mem_bus.we    = wr_strobe & (ptr_r != rtca_pkg::ADDR_FLAGS);

  // alarm banks follow writes to their address windows
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      al1_r <= '0;
      al2_r <= '0;
    end
    else if (wr_strobe)
    begin
      if (ptr_r >= rtca_pkg::ADDR_AL1_BASE
          && ptr_r <= rtca_pkg::ADDR_AL1_LAST)
        al1_r[3'(ptr_r - rtca_pkg::ADDR_AL1_BASE)] <= rx_byte;
      if (ptr_r >= rtca_pkg::ADDR_AL2_BASE
          && ptr_r <= rtca_pkg::ADDR_AL2_LAST)
        al2_r[3'(ptr_r - rtca_pkg::ADDR_AL2_BASE)] <= rx_byte;
    end
  end

  // control bits follow writes to their registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      trim_r      <= rtca_pkg::RST_BYTE;
      al2_en_r    <= rtca_pkg::RST_FLAG;  // alarm 2 off after reset
      osc_stop_r  <= rtca_pkg::RST_FLAG;
      out_level_r <= rtca_pkg::RST_FLAG;
      freq_test_r <= rtca_pkg::RST_FLAG;
    end
    else if (wr_strobe)
    begin
      unique case (ptr_r)
        rtca_pkg::ADDR_TRIM:
          trim_r <= rx_byte;
        rtca_pkg::ADDR_AL2_CTL:
          al2_en_r <= rx_byte[rtca_pkg::BIT_AL2_ENABLE];
        rtca_pkg::ADDR_SECONDS:
          osc_stop_r <= rx_byte[rtca_pkg::BIT_OSC_STOP];
        rtca_pkg::ADDR_DIG_CAL:
        begin
          out_level_r <= rx_byte[rtca_pkg::BIT_OUT_LEVEL];
          freq_test_r <= rx_byte[rtca_pkg::BIT_FREQ_TEST];
        end
        default:
          ;
      endcase
    end
  end

  // one evaluation per seconds update, held off on the flags address
  assign hit1 = sec_tick & (ptr_r != rtca_pkg::ADDR_FLAGS)
              & rtca_alarm_match(al1_r, cur_second, cur_minute,
                                 cur_hour, cur_date, cur_month);
  assign hit2 = sec_tick & al2_en_r
              & (ptr_r != rtca_pkg::ADDR_FLAGS)
              & rtca_alarm_match(al2_r, cur_second, cur_minute,
                                 cur_hour, cur_date, cur_month);

  // loading the flags byte for a read clears both alarm flags
  assign flags_clear = tx_load & (ptr_r == rtca_pkg::ADDR_FLAGS);

  // set wins over the clearing read in the same cycle
  assign af1_nxt = hit1 | (af1_r & ~flags_clear);
  assign af2_nxt = hit2 | (af2_r & ~flags_clear);

  // sticky alarm flags, no supply gating so backup mode keeps them
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      af1_r <= rtca_pkg::RST_FLAG;
      af2_r <= rtca_pkg::RST_FLAG;
    end
    else
    begin
      af1_r <= af1_nxt;
      af2_r <= af2_nxt;
    end
  end

  // square wave from the raw divider tap, ahead of digital correction
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ft_sq_r <= 1'b0;
    else if (tick_1024hz)
      ft_sq_r <= ~ft_sq_r;
  end

  // alarm interrupt gated by the first alarm enable
  assign alarm_irq = al1_r[rtca_pkg::AL_MONTH][rtca_pkg::BIT_A1_IRQ_EN]
                   & (af1_r | af2_r);

  // combined output: test square, else alarm low, else level bit
  always_comb
  begin
    if (freq_test_r && out_level_r && !osc_stop_r)
      int_out_nxt = ft_sq_r;
    else if (alarm_irq)
      int_out_nxt = 1'b0;
    else
      int_out_nxt = out_level_r;
  end

  // registered pin drive
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      int_out_r <= 1'b0;
    else
      int_out_r <= int_out_nxt;
  end

  assign interrupt_test_output_n = int_out_r;

endmodule : rtca_top

//--- tb/rtca_top_monitor.sv
/*
  rtca_top_monitor: port-level checks of the alarm and trim block.
  Assumes it is bound onto rtca_top and sees only its ports.
*/
`timescale 1ns/100ps
module rtca_top_monitor #(
  parameter int REG_DEPTH = 32
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       spi_scl,
  input wire logic       spi_sdi,
  input wire logic       spi_ce_n,
  input wire logic       spi_sdo,
  input wire logic       spi_sdo_oe,
  input wire logic       sec_tick,
  input wire logic [6:0] cur_second,
  input wire logic [6:0] cur_minute,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_date,
  input wire logic [4:0] cur_month,
  input wire logic       tick_1024hz,
  input wire logic       battery_low_flag,
  input wire logic       oscillator_fail_flag,
  input wire logic       interrupt_test_output_n,
  input wire logic [7:0] osc_side_cap_qpf,
  input wire logic       trim_code_valid
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // frame end and alarm hit as named steps
  sequence s_ce_up;
    $rose(spi_ce_n);
  endsequence
  sequence s_alarm_hit;
    sec_tick ##2 $fell(interrupt_test_output_n);
  endsequence

  chk_invalid_nominal: assert property
    (!trim_code_valid |-> osc_side_cap_qpf == 8'h64)
    else $error("invalid trim not at nominal");
  chk_cap_bounds: assert property
    (trim_code_valid |-> osc_side_cap_qpf inside {[8'h1C:8'h8B]})
    else $error("trim capacitance out of range");
  chk_cap_static: assert property
    ($changed(osc_side_cap_qpf) |-> !$past(spi_ce_n, 3))
    else $error("capacitance moved without a write");
  chk_cap_reset: assert property
    ($rose(rst_n) |-> osc_side_cap_qpf == 8'h64 && trim_code_valid)
    else $error("capacitance not nominal after reset");
  chk_pin_fall: assert property
    ($fell(interrupt_test_output_n) |-> $past(sec_tick, 2)
      || $past(tick_1024hz, 2) || !$past(spi_ce_n, 3))
    else $error("pin fell without a cause");
  chk_pin_rise: assert property
    ($rose(interrupt_test_output_n) |-> $past(tick_1024hz, 2)
      || !$past(spi_ce_n, 3))
    else $error("pin released outside a read");
  chk_oe_frame: assert property
    ($rose(spi_sdo_oe) |-> !spi_ce_n)
    else $error("output enabled outside a frame");
  chk_oe_release: assert property
    (s_ce_up |-> ##[1:5] !spi_sdo_oe)
    else $error("output enable stuck after frame");
  chk_sdo_steady: assert property
    (spi_sdo_oe && $changed(spi_sdo) |-> !spi_scl)
    else $error("read data moved while clock high");
  cov_alarm: cover property (s_alarm_hit);
endmodule : rtca_top_monitor

bind rtca_top rtca_top_monitor #(.REG_DEPTH(REG_DEPTH)) u_mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .spi_scl(spi_scl),
  .spi_sdi(spi_sdi), .spi_ce_n(spi_ce_n), .spi_sdo(spi_sdo),
  .spi_sdo_oe(spi_sdo_oe), .sec_tick(sec_tick),
  .cur_second(cur_second), .cur_minute(cur_minute),
  .cur_hour(cur_hour), .cur_date(cur_date), .cur_month(cur_month),
  .tick_1024hz(tick_1024hz), .battery_low_flag(battery_low_flag),
  .oscillator_fail_flag(oscillator_fail_flag),
  .interrupt_test_output_n(interrupt_test_output_n),
  .osc_side_cap_qpf(osc_side_cap_qpf), .trim_code_valid(trim_code_valid)
);

//--- tb/rtca_spi_host.sv
/*
  rtca_spi_host: host model, SPI master, clock idles low, msb first.
  Assumes clk_sys paces it: ten cycles per half period of the link clock.
*/
`timescale 1ns/100ps
module rtca_spi_host (
  input  wire logic clk_sys,
  output logic      spi_scl,
  output logic      spi_sdi,
  output logic      spi_ce_n,
  input  wire logic spi_sdo
);
  // link idle: clock still, chip off
  initial
  begin
    spi_scl  = 1'b0;
    spi_sdi  = 1'b0;
    spi_ce_n = 1'b1;
  end

  task automatic half;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask : half

  // one byte each way, read data taken at each rising clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_sdi = tx[i];
      half();
      spi_scl = 1'b1;
      rx[i]   = spi_sdo;
      half();
      spi_scl = 1'b0;
    end
  endtask : xfer

  // command byte then one data byte; released data line drifts
  task automatic frame(input logic [7:0] cmd, input logic [7:0] d,
                       output logic [7:0] rx);
    logic [7:0] dummy;
    half();
    spi_ce_n = 1'b0;
    half();
    xfer(cmd, dummy);
    xfer(d, rx);
    half();
    spi_ce_n = 1'b1;
    spi_sdi  = ~spi_sdi;
  endtask : frame
endmodule : rtca_spi_host

//--- tb/rtca_top_tb.sv
/*
  rtca_top_tb: self-checking bench of the alarm and trim block.
  Assumes the host model drives the link and the bench drives time.
*/
`timescale 1ns/100ps
module rtca_top_tb;
  logic       clk_sys, rst_n, spi_scl, spi_sdi, spi_ce_n, spi_sdo;
  logic       spi_sdo_oe, sec_tick, tick_1024hz, trim_code_valid;
  logic       battery_low_flag, oscillator_fail_flag, pin_n, hit, p;
  logic [6:0] cur_second, cur_minute;
  logic [5:0] cur_hour, cur_date;
  logic [4:0] cur_month, rpt;
  logic [7:0] osc_side_cap_qpf, rd, code, bank [5];
  logic [7:0] corner [10] = '{8'h00, 8'h80, 8'h0C, 8'h14, 8'h9C,
                              8'h27, 8'hC8, 8'h28, 8'hC9, 8'h7F};
  logic [4:0] modes [6] = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00};
  int         failures, check_count, k;

  rtca_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .spi_scl(spi_scl),
    .spi_sdi(spi_sdi), .spi_ce_n(spi_ce_n), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .sec_tick(sec_tick),
    .cur_second(cur_second), .cur_minute(cur_minute),
    .cur_hour(cur_hour), .cur_date(cur_date), .cur_month(cur_month),
    .tick_1024hz(tick_1024hz), .battery_low_flag(battery_low_flag),
    .oscillator_fail_flag(oscillator_fail_flag),
    .interrupt_test_output_n(pin_n),
    .osc_side_cap_qpf(osc_side_cap_qpf),
    .trim_code_valid(trim_code_valid));
  rtca_spi_host host (.clk_sys(clk_sys), .spi_scl(spi_scl),
    .spi_sdi(spi_sdi), .spi_ce_n(spi_ce_n), .spi_sdo(spi_sdo));

  // 250 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // expected {valid, per-side capacitance} of a trim byte
  function automatic logic [8:0] cap_exp(input logic [7:0] c);
    if (c[6:0] == 7'h00) return 9'h164;
    if (!c[7] && c[6:0] <= 7'h27) return {1'b1, 8'h64 + {1'b0, c[6:0]}};
    if (c[7] && c[6:0] <= 7'h48) return {1'b1, 8'h64 - {1'b0, c[6:0]}};
    return 9'h064;
  endfunction : cap_exp

  // a set repeat bit leaves that field out; odd codes fire every second
  function automatic logic hit_exp(input logic [4:0] r, input int f);
    if (r inside {5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00}) return r[f];
    return 1'b1;
  endfunction : hit_exp

  task automatic chk(input string w, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame({3'h4, a}, d, r);
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    host.frame({3'h0, a}, 8'h00, d);
  endtask : reg_rd

  // one-cycle pulse on a tick input, then let the outputs settle
  task automatic pulse(input bit slow);
    @(posedge clk_sys);
    #1;
    if (slow) sec_tick = 1'b1; else tick_1024hz = 1'b1;
    @(posedge clk_sys);
    #1;
    sec_tick    = 1'b0;
    tick_1024hz = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : pulse

  // time equal to the alarm bank except in field f (5: none)
  task automatic set_time(input int f);
    cur_second = 7'h05 ^ 7'(f == 0);
    cur_minute = 7'h04 ^ 7'(f == 1);
    cur_hour   = 6'h03 ^ 6'(f == 2);
    cur_date   = 6'h02 ^ 6'(f == 3);
    cur_month  = 5'h01 ^ 5'(f == 4);
  endtask : set_time

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // hang guard
  initial
  begin
    #300us;
    failures++;
    $display("FAIL watchdog expected end seen hang");
    test_done();
  end

  // main sequence
  initial
  begin
    {rst_n, sec_tick, tick_1024hz} = 3'h0;
    {battery_low_flag, oscillator_fail_flag} = 2'h0;
    set_time(5);
    failures    = 0;
    check_count = 0;
    void'($urandom(21));
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("cap reset", 9'h164, {trim_code_valid, osc_side_cap_qpf});
    chk("pin reset", 9'h000, {8'h00, pin_n});
    for (int i = 0; i < 16; i++)
    begin
      code = (i < 10) ? corner[i] : 8'($urandom);
      reg_wr(rtca_pkg::ADDR_TRIM, code);
      chk("trim cap", cap_exp(code), {trim_code_valid, osc_side_cap_qpf});
      reg_rd(rtca_pkg::ADDR_TRIM, rd);
      chk("trim reg", {1'b0, code}, {1'b0, rd});
    end
    reg_wr(rtca_pkg::ADDR_DIG_CAL, 8'h80);
    for (int j = 0; j < 5; j++)
      reg_wr(5'(rtca_pkg::ADDR_AL2_BASE + j), (j == 1) ? 8'hC2 : 8'h80);
    for (int n = 0; n < 14; n++)
    begin
      rpt  = (n < 6) ? modes[n] : 5'($urandom);
      k    = $urandom_range(4, 0);
      bank = '{8'h81, {rpt[3], rpt[4], 4'h0, |rpt, 1'b0}, {rpt[2], 7'h03},
               {rpt[1], 7'h04}, {rpt[0], 7'h05}};
      for (int j = 0; j < 5; j++)
        reg_wr(5'(rtca_pkg::ADDR_AL1_BASE + j), bank[j]);
      {battery_low_flag, oscillator_fail_flag} = 2'($urandom);
      set_time(5);
      pulse(1'b1);
      reg_rd(rtca_pkg::ADDR_FLAGS, rd);
      chk("flags parked", {4'h0, battery_low_flag, 1'b0,
          oscillator_fail_flag, 2'h0}, {1'b0, rd});
      set_time(k);
      pulse(1'b1);
      hit = hit_exp(rpt, k);
      chk("alarm pin", {8'h00, ~hit}, {8'h00, pin_n});
      reg_rd(rtca_pkg::ADDR_FLAGS, rd);
      chk("flags hit", {2'h0, hit, 1'b0, battery_low_flag, 1'b0,
          oscillator_fail_flag, 2'h0}, {1'b0, rd});
      chk("pin cleared", 9'h001, {8'h00, pin_n});
    end
    reg_wr(rtca_pkg::ADDR_FLAGS, 8'hFF);
    reg_wr(rtca_pkg::ADDR_AL2_CTL, 8'h02);
    set_time(5);
    pulse(1'b1);
    reg_rd(rtca_pkg::ADDR_FLAGS, rd);
    chk("alarm2 flag", 9'h020, {1'b0, rd & 8'hAB});
    reg_wr(rtca_pkg::ADDR_DIG_CAL, 8'hC0);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6) reg_wr(rtca_pkg::ADDR_SECONDS, 8'h80);
      p = pin_n;
      pulse(1'b0);
      chk("test pin", {8'h00, (i < 6) ? ~p : p}, {8'h00, pin_n});
    end
    test_done();
  end
endmodule : rtca_top_tb
